// *** tou_consts.vh ***
// Purpose: constants for the trigger output unit
// Assumes: five trigger lines, four monitored channels, 16-bit measurements
// Notes:   condition codes follow the order of the condition list
`ifndef TOU_CONSTS_VH
`define TOU_CONSTS_VH

// Geometry
`define TOU_LINES        5
`define TOU_CHANS        4
`define TOU_MEAS_W       16
`define TOU_LINE_IDX_W   3
`define TOU_CHAN_IDX_W   2
`define TOU_COND_W       4

// Condition codes
`define TOU_COND_OFF     4'h0
`define TOU_COND_ON      4'h1
`define TOU_COND_GT_V    4'h2
`define TOU_COND_LT_V    4'h3
`define TOU_COND_EQ_V    4'h4
`define TOU_COND_GT_C    4'h5
`define TOU_COND_LT_C    4'h6
`define TOU_COND_EQ_C    4'h7
`define TOU_COND_GT_P    4'h8
`define TOU_COND_LT_P    4'h9
`define TOU_COND_EQ_P    4'hA
`define TOU_COND_AUTO    4'hB

// Reset values
`define TOU_RST_COND     4'h0
`define TOU_RST_THRESH   16'h0000
`define TOU_RST_CHAN     2'h0
`define TOU_RST_ENABLE   1'b0
`define TOU_RST_POL_NEG  1'b0

// Equality window, in measurement LSBs
`define TOU_EQ_TOL       16'h0001

`endif

// *** tou_line_eval.v ***
// Purpose: evaluates one trigger line's condition against its channel
// Assumes: measurements are unsigned and in the same units as threshold
// Notes:   purely combinational; registered in the parent
`timescale 1ns/1ps
`include "tou_consts.vh"

module tou_line_eval (
  // Settings
  input  wire [`TOU_COND_W-1:0] cond,
  input  wire [`TOU_MEAS_W-1:0] threshold,
  // Monitored channel
  input  wire                   chanOutEn,
  input  wire [`TOU_MEAS_W-1:0] voltage,
  input  wire [`TOU_MEAS_W-1:0] current,
  input  wire [`TOU_MEAS_W-1:0] power,
  // Result
  output reg                    met
);

  // Equal within one step either way
  function isNear;
    input [`TOU_MEAS_W-1:0] a;
    input [`TOU_MEAS_W-1:0] b;
    begin
      if (a >= b)
        isNear = (a - b) <= `TOU_EQ_TOL; // [R18]
      else
        isNear = (b - a) <= `TOU_EQ_TOL; // [R18]
    end
  endfunction

  // Compare code 0..2 = greater, less, equal
  function cmp3;
    input [1:0]             sel;
    input [`TOU_MEAS_W-1:0] meas;
    input [`TOU_MEAS_W-1:0] thr;
    begin
      case (sel)
        2'h0:    cmp3 = meas > thr;
        2'h1:    cmp3 = meas < thr;
        default: cmp3 = isNear(meas, thr);
      endcase
    end
  endfunction

  wire vAny = cmp3(2'h0, voltage, threshold) | cmp3(2'h1, voltage, threshold) |
              cmp3(2'h2, voltage, threshold);
  wire cAny = cmp3(2'h0, current, threshold) | cmp3(2'h1, current, threshold) |
              cmp3(2'h2, current, threshold);
  wire pAny = cmp3(2'h0, power, threshold) | cmp3(2'h1, power, threshold) |
              cmp3(2'h2, power, threshold);

  // Condition decode
  always @* begin
    case (cond)
      `TOU_COND_OFF:  met = ~chanOutEn;                       // [R2]
      `TOU_COND_ON:   met = chanOutEn;                        // [R2]
      `TOU_COND_GT_V: met = cmp3(2'h0, voltage, threshold);   // [R3]
      `TOU_COND_LT_V: met = cmp3(2'h1, voltage, threshold);   // [R3]
      `TOU_COND_EQ_V: met = cmp3(2'h2, voltage, threshold);   // [R3]
      `TOU_COND_GT_C: met = cmp3(2'h0, current, threshold);   // [R4]
      `TOU_COND_LT_C: met = cmp3(2'h1, current, threshold);   // [R4]
      `TOU_COND_EQ_C: met = cmp3(2'h2, current, threshold);   // [R4]
      `TOU_COND_GT_P: met = cmp3(2'h0, power, threshold);     // [R5]
      `TOU_COND_LT_P: met = cmp3(2'h1, power, threshold);     // [R5]
      `TOU_COND_EQ_P: met = cmp3(2'h2, power, threshold);     // [R5]
      // Any of the comparisons against the one threshold
      `TOU_COND_AUTO: met = vAny | cAny | pAny;               // [R6]
      default:        met = 1'b0;
    endcase
  end

endmodule // tou_line_eval

// *** tou_trigger_out.v ***
// Purpose: five-line trigger output unit with per-line settings and readback
// Assumes: host writes one setting per strobe; channel data is synchronous
// Notes:   settings are plain ports; no bus. Outputs are registered.
//          Auto compares all three quantities with the one threshold.
//          Line indices above four are ignored on write and read as zeros.
//
// Operation
// [R1] Off, on and automatic conditions are taken without a threshold.
// [R2] Off/on conditions fire when the channel output is disabled/enabled.
// [R3] Voltage conditions fire on above, below or equal to threshold.
// [R4] Current conditions fire on above, below or equal to threshold.
// [R5] Power conditions fire on above, below or equal to threshold.
// [R6] Automatic fires when any voltage, current or power comparison holds.
// [R7] Host supplies a threshold with every comparison condition.
// [R8] Programmed condition of a selected line is readable.
// [R9] Per-line enable; a disabled line drives no trigger.
// [R10] Enabled line meeting its condition drives the configured signal.
// [R11] Enable state of a selected line is readable.
// [R12] Positive polarity drives the configured signal unchanged.
// [R13] Negative polarity drives the configured signal inverted.
// [R14] Polarity of a selected line is readable.
// [R15] Any of four channels may be the monitored source of each line.
// [R16] Monitored channel of a selected line is readable.
// [R17] All settings are kept per line and lines evaluate independently.
// [R18] Equality holds within one measurement step of the threshold.
`timescale 1ns/1ps
`include "tou_consts.vh"

module tou_trigger_out (
  // Clock and reset
  input  wire                                 ref_clk,
  input  wire                                 rst_n,
  // Host settings write
  input  wire [`TOU_LINE_IDX_W-1:0]           wrLine,
  input  wire                                 wrCondStb,
  input  wire [`TOU_COND_W-1:0]               wrCond,
  input  wire [`TOU_MEAS_W-1:0]               wrThreshold,
  input  wire                                 wrEnableStb,
  input  wire                                 wrEnable,
  input  wire                                 wrPolarityStb,
  input  wire                                 wrPolarityNeg,
  input  wire                                 wrSourceStb,
  input  wire [`TOU_CHAN_IDX_W-1:0]           wrSource,
  // Host query
  input  wire [`TOU_LINE_IDX_W-1:0]           rdLine,
  output reg  [`TOU_COND_W-1:0]               rdCond,
  output reg  [`TOU_MEAS_W-1:0]               rdThreshold,
  output reg                                  rdEnable,
  output reg                                  rdPolarityNeg,
  output reg  [`TOU_CHAN_IDX_W-1:0]           rdSource,
  // Channel monitors, channel n in slice n
  input  wire [`TOU_CHANS-1:0]                chanOutEn,
  input  wire [`TOU_CHANS*`TOU_MEAS_W-1:0]    chanVoltage,
  input  wire [`TOU_CHANS*`TOU_MEAS_W-1:0]    chanCurrent,
  input  wire [`TOU_CHANS*`TOU_MEAS_W-1:0]    chanPower,
  // Configured level or square wave per line
  input  wire [`TOU_LINES-1:0]                lineSignal,
  // Trigger lines, their drive enables and per-line condition status
  output reg  [`TOU_LINES-1:0]                triggerLine,
  output reg  [`TOU_LINES-1:0]                triggerLineOe,
  output reg  [`TOU_LINES-1:0]                conditionMet
);

  // Per-line setting storage
  reg [`TOU_COND_W-1:0]     cond      [0:`TOU_LINES-1];
  reg [`TOU_MEAS_W-1:0]     threshold [0:`TOU_LINES-1];
  reg [`TOU_CHAN_IDX_W-1:0] source    [0:`TOU_LINES-1];
  reg [`TOU_LINES-1:0]      enable;
  reg [`TOU_LINES-1:0]      polarityNeg;

  // Evaluator results and next values of the registered outputs
  wire [`TOU_LINES-1:0]      next_met;
  reg  [`TOU_LINES-1:0]      next_conditionMet;
  reg  [`TOU_LINES-1:0]      next_triggerLineOe;
  reg  [`TOU_LINES-1:0]      next_triggerLine;
  reg  [`TOU_COND_W-1:0]     next_rdCond;
  reg  [`TOU_MEAS_W-1:0]     next_rdThreshold;
  reg                        next_rdEnable;
  reg                        next_rdPolarityNeg;
  reg  [`TOU_CHAN_IDX_W-1:0] next_rdSource;

  // All lines idle
  localparam [`TOU_LINES-1:0] NO_LINES = {`TOU_LINES{1'b0}};

  // Line index decode, shared by the write and query sides
  function lineInRange;
    input [`TOU_LINE_IDX_W-1:0] idx;
    begin
      lineInRange = (idx < `TOU_LINES);
    end
  endfunction

  // Comparison conditions need the threshold
  function needsThreshold;
    input [`TOU_COND_W-1:0] c;
    begin
      needsThreshold = (c != `TOU_COND_OFF) && (c != `TOU_COND_ON) &&
                       (c != `TOU_COND_AUTO);
    end
  endfunction

  // Channel slice select; the three measurement buses share one layout
  function [`TOU_MEAS_W-1:0] chanSlice;
    input [`TOU_CHANS*`TOU_MEAS_W-1:0] bus;
    input [`TOU_CHAN_IDX_W-1:0]        ch;
    begin
      chanSlice = bus[ch*`TOU_MEAS_W +: `TOU_MEAS_W];
    end
  endfunction

  // Write qualifiers; out-of-range line numbers are ignored
  wire wrLineOk = lineInRange(wrLine);
  wire rdLineOk = lineInRange(rdLine);
  wire condWe   = wrLineOk & wrCondStb;
  // A threshold only rides along with a comparison condition
  wire thrWe    = condWe & needsThreshold(wrCond);    // [R1] [R7]
  wire enableWe = wrLineOk & wrEnableStb;
  wire polWe    = wrLineOk & wrPolarityStb;
  wire sourceWe = wrLineOk & wrSourceStb;

  // Settings writes; strobes may coincide, each lands in its own field
  integer i;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Off, threshold zero, first channel, disabled, positive
      for (i = 0; i < `TOU_LINES; i = i + 1) begin
        cond[i]      <= `TOU_RST_COND;
        threshold[i] <= `TOU_RST_THRESH;
        source[i]    <= `TOU_RST_CHAN;
      end
      enable      <= {`TOU_LINES{`TOU_RST_ENABLE}};
      polarityNeg <= {`TOU_LINES{`TOU_RST_POL_NEG}};
    end else begin
      if (condWe)
        cond[wrLine] <= wrCond;                          // [R17]
      // Threshold kept as is for off/on/auto
      if (thrWe)
        threshold[wrLine] <= wrThreshold;                // [R1] [R7]
      if (enableWe)
        enable[wrLine] <= wrEnable;                      // [R9]
      if (polWe)
        polarityNeg[wrLine] <= wrPolarityNeg;            // [R12] [R13]
      if (sourceWe)
        source[wrLine] <= wrSource;                      // [R15]
    end
  end

  // One evaluator per line; a new source applies from the next edge
  genvar g;
  generate
    for (g = 0; g < `TOU_LINES; g = g + 1) begin : gLine
      wire [`TOU_CHAN_IDX_W-1:0] ch       = source[g];
      wire [`TOU_MEAS_W-1:0]     selVolt  = chanSlice(chanVoltage, ch);
      wire [`TOU_MEAS_W-1:0]     selCurr  = chanSlice(chanCurrent, ch);
      wire [`TOU_MEAS_W-1:0]     selPower = chanSlice(chanPower, ch);
      tou_line_eval uEval (
        .cond      (cond[g]),
        .threshold (threshold[g]),
        .chanOutEn (chanOutEn[ch]),
        .voltage   (selVolt),
        .current   (selCurr),
        .power     (selPower),
        .met       (next_met[g])
      );                                                 // [R15] [R17]
    end
  endgenerate

  // Drive decode: a line only drives while enabled and met
  always @* begin
    next_conditionMet  = next_met & enable;
    // Disabled line is released, never driven
    next_triggerLineOe = next_met & enable;                              // [R9] [R10]
    // Negative polarity flips the configured signal
    next_triggerLine   = next_met & enable & (lineSignal ^ polarityNeg); // [R10] [R12] [R13]
  end

  // Line drive: registered to keep glitches off the pins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // All lines released while in reset
      conditionMet  <= NO_LINES;
      triggerLine   <= NO_LINES;
      triggerLineOe <= NO_LINES;
    end else begin
      conditionMet  <= next_conditionMet;
      triggerLineOe <= next_triggerLineOe;
      triggerLine   <= next_triggerLine;
    end
  end

  // Query mux; an unused line index reads as all zeros
  always @* begin
    // Defaults first, so every path assigns
    next_rdCond        = `TOU_RST_COND;
    next_rdThreshold   = `TOU_RST_THRESH;
    next_rdEnable      = 1'b0;
    next_rdPolarityNeg = 1'b0;
    next_rdSource      = `TOU_RST_CHAN;
    if (rdLineOk) begin
      next_rdCond        = cond[rdLine];        // [R8]
      next_rdThreshold   = threshold[rdLine];
      next_rdEnable      = enable[rdLine];      // [R11]
      next_rdPolarityNeg = polarityNeg[rdLine]; // [R14]
      next_rdSource      = source[rdLine];      // [R16]
    end
  end

  // Query readback, one cycle after rdLine
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Nothing is reported while in reset
      rdCond        <= `TOU_RST_COND;
      rdThreshold   <= `TOU_RST_THRESH;
      rdEnable      <= `TOU_RST_ENABLE;
      rdPolarityNeg <= `TOU_RST_POL_NEG;
      rdSource      <= `TOU_RST_CHAN;
    end else begin
      rdCond        <= next_rdCond;
      rdThreshold   <= next_rdThreshold;
      rdEnable      <= next_rdEnable;
      rdPolarityNeg <= next_rdPolarityNeg;
      rdSource      <= next_rdSource;
    end
  end

endmodule // tou_trigger_out

// *** tou_listener.sv ***
// Purpose: far-side listener resolving the trigger wires
// Assumes: each wire has a pull-down at the listener
// Notes:   a released wire reads low, never its last value
`timescale 1ns/1ps
module tou_listener (
  // Unit side
  input  wire [4:0] triggerLine,
  input  wire [4:0] triggerLineOe,
  // Resolved wire levels
  output wire [4:0] wireLevel
);
  // Pull-down wins whenever the unit releases a line
  assign wireLevel = triggerLine & triggerLineOe;
endmodule // tou_listener

// *** tou_trigger_out_assertions.sv ***
// Purpose: port-level checks of the trigger output unit
// Assumes: a write shows on readback two edges after its strobe
// Notes:   lines above 4 read back as zeros
`timescale 1ns/1ps
module tou_trigger_out_assertions (
  // Clock and host side
  input wire        ref_clk,
  input wire        rst_n,
  input wire [2:0]  wrLine,
  input wire        wrCondStb,
  input wire [3:0]  wrCond,
  input wire [15:0] wrThreshold,
  input wire        wrEnableStb,
  input wire        wrEnable,
  input wire        wrPolarityStb,
  input wire        wrPolarityNeg,
  input wire [2:0]  rdLine,
  input wire [3:0]  rdCond,
  input wire [15:0] rdThreshold,
  input wire        rdEnable,
  input wire        rdPolarityNeg,
  input wire [1:0]  rdSource,
  // Line side
  input wire [4:0]  triggerLine,
  input wire [4:0]  triggerLineOe,
  input wire [4:0]  conditionMet
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Written line is queried in the cycle after the write
  sequence s_rd; rdLine == $past(wrLine); endsequence
  property p_cond; (wrCondStb && wrLine < 3'h5) ##1 s_rd |=> rdCond == $past(wrCond, 2);
  endproperty
  a_cond: assert property (p_cond) else $error("condition readback wrong");
  property p_thr; (wrCondStb && wrLine < 3'h5 && wrCond inside {[2:10]}) ##1 s_rd
    |=> rdThreshold == $past(wrThreshold, 2); endproperty
  a_thr: assert property (p_thr) else $error("threshold not stored");
  // Codes without a value must leave the threshold alone
  property p_keep; (wrCondStb && wrLine < 3'h5 && wrCond inside {0, 1, 11} && rdLine == wrLine)
    ##1 (rdLine == $past(rdLine)) |=> $stable(rdThreshold); endproperty
  a_keep: assert property (p_keep) else $error("threshold changed");
  property p_en; (wrEnableStb && wrLine < 3'h5) ##1 s_rd |=> rdEnable == $past(wrEnable, 2);
  endproperty
  a_en: assert property (p_en) else $error("enable readback wrong");
  property p_pol; (wrPolarityStb && wrLine < 3'h5) ##1 s_rd
    |=> rdPolarityNeg == $past(wrPolarityNeg, 2); endproperty
  a_pol: assert property (p_pol) else $error("polarity readback wrong");
  property p_rng; $past(rdLine) > 3'h4 |-> {rdCond, rdThreshold, rdEnable, rdPolarityNeg,
    rdSource} == 24'h0; endproperty
  a_rng: assert property (p_rng) else $error("bad line index not zero");
  // A line switched off is released two edges after the write
  property p_oe; (wrEnableStb && wrLine < 3'h5 && !wrEnable) |=> ##1
    !triggerLineOe[$past(wrLine, 2)]; endproperty
  a_oe: assert property (p_oe) else $error("disabled line still driven");
  property p_off; (triggerLine & ~triggerLineOe) == 5'h00; endproperty
  a_off: assert property (p_off) else $error("released line high");
  c_met: cover property (conditionMet[0]);
  c_neg: cover property (triggerLineOe[2] && !triggerLine[2]);
  c_rng: cover property (rdLine > 3'h4);
endmodule // tou_trigger_out_assertions
bind tou_trigger_out tou_trigger_out_assertions u_chk (.ref_clk, .rst_n, .wrLine, .wrCondStb,
  .wrCond, .wrThreshold, .wrEnableStb, .wrEnable, .wrPolarityStb, .wrPolarityNeg, .rdLine,
  .rdCond, .rdThreshold, .rdEnable, .rdPolarityNeg, .rdSource, .triggerLine, .triggerLineOe,
  .conditionMet);

// *** tou_trigger_out_tb.sv ***
// Purpose: self-checking bench of the trigger output unit
// Assumes: fixed latencies, no handshake on any port
// Notes:   channel 1 measures V 100, C 200, P 300
`timescale 1ns/1ps
module tou_trigger_out_tb;
  reg         ref_clk = 1'b0, rst_n = 1'b0;
  reg  [2:0]  wrLine = 3'h0, rdLine = 3'h0;
  reg  [3:0]  wrCond = 4'h0, chanOutEn = 4'h2;
  reg  [15:0] wrThreshold = 16'h0000;
  reg  [1:0]  wrSource = 2'h0;
  reg         wrCondStb = 1'b0, wrEnableStb = 1'b0, wrPolarityStb = 1'b0, wrSourceStb = 1'b0;
  reg         wrEnable = 1'b0, wrPolarityNeg = 1'b0;
  reg  [63:0] chanVoltage = 64'h0000_0000_0064_0000, chanCurrent = 64'h0000_0000_00C8_0000;
  reg  [63:0] chanPower = 64'h0000_0000_012C_0000;
  reg  [4:0]  lineSignal = 5'h1F;
  reg  [12:0] expMet = 13'h0D56;
  reg  [15:0] thr [13] = '{16'h0, 16'h0, 16'h63, 16'h63, 16'h65, 16'hC8, 16'hC9, 16'hCA,
    16'h12B, 16'h12B, 16'h12B, 16'h0, 16'h0};
  wire [3:0]  rdCond;
  wire [15:0] rdThreshold;
  wire [1:0]  rdSource;
  wire        rdEnable, rdPolarityNeg;
  wire [4:0]  triggerLine, triggerLineOe, conditionMet, wireLevel;
  integer     n_fail = 0, comparisons = 0, k;
  tou_trigger_out dut (.ref_clk, .rst_n, .wrLine, .wrCondStb, .wrCond, .wrThreshold,
    .wrEnableStb, .wrEnable, .wrPolarityStb, .wrPolarityNeg, .wrSourceStb, .wrSource, .rdLine,
    .rdCond, .rdThreshold, .rdEnable, .rdPolarityNeg, .rdSource, .chanOutEn, .chanVoltage,
    .chanCurrent, .chanPower, .lineSignal, .triggerLine, .triggerLineOe, .conditionMet);
  tou_listener u_far (.triggerLine, .triggerLineOe, .wireLevel);
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input bit ok, input string msg);
    comparisons = comparisons + 1;
    if (!ok) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // All four settings in one strobe, then query the same line
  task setl(input [2:0] l, input [3:0] c, input [15:0] t, input e, input p, input [1:0] s);
    @(posedge ref_clk);
    {wrLine, wrCond, wrThreshold, wrEnable, wrPolarityNeg, wrSource} <= {l, c, t, e, p, s};
    {wrCondStb, wrEnableStb, wrPolarityStb, wrSourceStb} <= 4'hF;
    rdLine <= l;
    @(posedge ref_clk);
    {wrCondStb, wrEnableStb, wrPolarityStb, wrSourceStb} <= 4'h0;
    cyc(2);
  endtask
  task t_lines;
    for (k = 0; k < 5; k = k + 1) setl(k[2:0], k[3:0] + 4'h2, 16'h0100 + k[15:0], k[0], k[1], k[1:0]);
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge ref_clk) rdLine <= k[2:0];
      cyc(2);
      chk(rdCond === k[3:0] + 4'h2 && rdThreshold === 16'h0100 + k[15:0], "cond readback");
      chk({rdPolarityNeg, rdEnable} === k[1:0] && rdSource === k[1:0], "flag readback");
    end
    @(posedge ref_clk) rdLine <= 3'h7;
    cyc(2);
    chk({rdCond, rdThreshold, rdEnable, rdSource} === 23'h0, "bad index");
    $display("t_lines done");
  endtask
  task t_keep;
    setl(3'h0, 4'h2, 16'h0050, 1'b0, 1'b0, 2'h1);
    setl(3'h0, 4'h0, 16'h00FF, 1'b0, 1'b0, 2'h1);
    chk(rdThreshold === 16'h0050 && rdCond === 4'h0, "threshold kept");
    $display("t_keep done");
  endtask
  task t_conds;
    for (k = 0; k < 13; k = k + 1) begin
      setl(3'h0, k[3:0], thr[k], 1'b1, 1'b0, 2'h1);
      chk(conditionMet[0] === expMet[k] && wireLevel[0] === expMet[k], "cond");
      chk(conditionMet[4:1] === 4'h1, "other lines");
    end
    $display("t_conds done");
  endtask
  task t_pol;
    setl(3'h2, 4'h1, 16'h0000, 1'b1, 1'b0, 2'h3);
    chk(conditionMet[2] === 1'b0, "on while off");
    @(posedge ref_clk) chanOutEn <= 4'hA;
    cyc(2);
    chk(triggerLineOe[2] === 1'b1 && wireLevel[2] === 1'b1, "positive");
    @(posedge ref_clk) lineSignal <= 5'h1B;
    cyc(2);
    chk(triggerLineOe[2] === 1'b1 && triggerLine[2] === 1'b0, "follows signal");
    setl(3'h2, 4'h1, 16'h0000, 1'b1, 1'b1, 2'h3);
    chk(triggerLine[2] === 1'b1 && rdPolarityNeg === 1'b1, "negative");
    setl(3'h2, 4'h1, 16'h0000, 1'b0, 1'b1, 2'h3);
    chk(triggerLineOe[2] === 1'b0 && wireLevel[2] === 1'b0, "disabled");
    setl(3'h2, 4'h0, 16'h0000, 1'b1, 1'b0, 2'h3);
    @(posedge ref_clk) chanOutEn <= 4'h2;
    cyc(2);
    chk(conditionMet[2] === 1'b1, "off condition");
    $display("t_pol done");
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(1);
    chk({rdCond, rdThreshold, rdEnable, rdPolarityNeg, triggerLineOe} === 27'h0, "reset");
    t_lines;
    t_keep;
    t_conds;
    t_pol;
    test_done;
  end
  // Hang guard
  initial begin
    #200000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // tou_trigger_out_tb
